// ---- rtl/bus_cond_pkg.sv ----
package bus_cond_pkg;
   // Register indices on the plain register port
   localparam logic [3:0] ADDR_BUS_COND = 4'h0;
   localparam logic [3:0] ADDR_MODE = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
   // bus_condition_control fields
   localparam int BIT_BUS_OCCUPIED = 7;
   localparam int BIT_START_STOP_INHIBIT = 6;
   localparam int BIT_SDA_OUTPUT_VALUE = 5;
   localparam int BIT_SDA_WRITE_GUARD = 4;
   localparam int BIT_SCL_OUTPUT_MONITOR = 3;
   localparam int BIT_CONTROL_PART_RESET = 1;
   localparam logic [7:0] BUS_COND_FIXED_ONES = 8'h55;
   // mode register fields
   localparam int BIT_MASTER_SELECT = 5;
   localparam int BIT_TRANSMIT_SELECT = 4;
   localparam int BIT_SYNC_FORMAT = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // interrupt status fields
   localparam int BIT_EV_START_SEEN = 0;
   localparam int BIT_EV_STOP_SEEN = 1;
   localparam int BIT_EV_COND_DONE = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   // Condition timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int COND_TIME_NS = 4700;
   localparam int COND_CYCLES = (COND_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SYNC_STAGES = 2;
endpackage

// ---- rtl/bus_condition_ctrl.sv ----
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
// What this block does
// - SDA falls, SCL high: set bus_occupied
// - SDA rises, SCL high: clear bus_occupied
// - Clocked synchronous format: bus_occupied left alone
// - Master write occupied=1, inhibit=0 issues start
// - Master write occupied=0, inhibit=0 issues stop
// - Inhibit=1 write issues no start or stop; inhibit reads 1
// - SDA value 0 drives low, 1 releases
// - SDA value reads back driven level
// - SDA value changes only with guard 0
// - Read-only bit shows SCL output level
// - Control-part reset resets protocol, keeps registers
// - Master mode when master_select is 1
module bus_condition_ctrl
   import bus_cond_pkg::*;
#(
   parameter int COND_WAIT = COND_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq
);

   if (COND_WAIT < 1 || COND_WAIT > 65535) begin : g_check
      $error("COND_WAIT out of range");
   end

   // Fewer stages would let a metastable level reach the edge compare
   if (SYNC_STAGES < 2) begin : g_sync_check
      $error("SYNC_STAGES below 2");
   end

   // Each step lasts COND_WAIT + 1 cycles so every line change keeps its hold time
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RS_SDA_UP,
      ST_RS_SCL_UP,
      ST_START_SDA_LOW,
      ST_START_SCL_LOW,
      ST_STOP_SDA_LOW,
      ST_STOP_SCL_UP,
      ST_STOP_SDA_UP
   } cond_state_e;

   cond_state_e state;
   // Sixteen bits; the elaboration check keeps COND_WAIT inside them
   logic [15:0] wait_cnt;
   logic [SYNC_STAGES-1:0] scl_sync;
   logic [SYNC_STAGES-1:0] sda_sync;
   logic scl_prev;
   logic sda_prev;
   logic bus_occupied;
   logic sw_sda_low;
   logic control_part_reset;
   logic [7:0] mode;
   logic fsm_sda_low;
   logic fsm_scl_low;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic ev_start;
   logic ev_stop;
   logic ev_done;
   logic wr_cond;
   logic master_mode;
   logic issue_start;
   logic issue_stop;
   logic wait_over;
   logic status_read;
   logic scl_steady;
   logic watch_bus;

   // Strobe qualified by register index, shared by every write decode and the status read
   function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
      input logic [3:0] index);
      return strobe && addr == index;
   endfunction

   // Readback of the condition register: fixed ones plus live status
   function automatic logic [7:0] bus_cond_view(input logic occupied, input logic sda_low,
      input logic scl_low, input logic part_reset);
      logic [7:0] view;
      view = BUS_COND_FIXED_ONES;
      view[BIT_BUS_OCCUPIED] = occupied;
      view[BIT_SDA_OUTPUT_VALUE] = !sda_low;
      view[BIT_SCL_OUTPUT_MONITOR] = !scl_low;
      view[BIT_CONTROL_PART_RESET] = part_reset;
      return view;
   endfunction

   // Lines are open-drain: only ever pulled low
   assign sda_out = 1'b0;
   assign scl_out = 1'b0;

   // Transmit and receive both count as master mode
   assign master_mode = mode[BIT_MASTER_SELECT];
   assign wr_cond = reg_hit(reg_write, reg_addr, ADDR_BUS_COND);
   // A command reaching a busy sequencer is dropped without notice
   assign issue_start = wr_cond && master_mode && !reg_wdata[BIT_START_STOP_INHIBIT]
      && reg_wdata[BIT_BUS_OCCUPIED];
   assign issue_stop = wr_cond && master_mode && !reg_wdata[BIT_START_STOP_INHIBIT]
      && !reg_wdata[BIT_BUS_OCCUPIED];
   // Zero means the current step has run its full time
   assign wait_over = wait_cnt == 16'h0000;
   assign status_read = reg_hit(reg_read, reg_addr, ADDR_IRQ_STATUS);
   // Clocked synchronous format gives occupancy no meaning, so bus events freeze
   assign watch_bus = !mode[BIT_SYNC_FORMAT];

   // Two flops before anything looks at the pins
   always_ff @(posedge clk) begin
      if (srst) begin
         scl_sync <= '1;
         sda_sync <= '1;
      end else begin
         scl_sync <= {scl_sync[SYNC_STAGES-2:0], scl_in};
         sda_sync <= {sda_sync[SYNC_STAGES-2:0], sda_in};
      end
   end

   // One more stage keeps the last level for the edge compare
   always_ff @(posedge clk) begin
      if (srst) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_sync[SYNC_STAGES-1];
         sda_prev <= sda_sync[SYNC_STAGES-1];
      end
   end

   // Condition seen only when SCL stays high across the SDA edge
   assign scl_steady = scl_prev && scl_sync[SYNC_STAGES-1];
   assign ev_start = scl_steady && sda_prev && !sda_sync[SYNC_STAGES-1];
   assign ev_stop = scl_steady && !sda_prev && sda_sync[SYNC_STAGES-1];

   // Bus occupancy is a register, so the control-part reset leaves it alone
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_occupied <= 1'b0;
      end else if (watch_bus) begin
         if (ev_start) begin
            bus_occupied <= 1'b1;
         end else if (ev_stop) begin
            bus_occupied <= 1'b0;
         end
      end
   end

   // Direct SDA control through the guarded bit
   always_ff @(posedge clk) begin
      if (srst) begin
         sw_sda_low <= 1'b0;
      end else if (wr_cond && !reg_wdata[BIT_SDA_WRITE_GUARD]) begin
         sw_sda_low <= !reg_wdata[BIT_SDA_OUTPUT_VALUE];
      end
   end

   // Not self-clearing: the sequencer stays idle until software writes 0
   always_ff @(posedge clk) begin
      if (srst) begin
         control_part_reset <= 1'b0;
      end else if (wr_cond) begin
         control_part_reset <= reg_wdata[BIT_CONTROL_PART_RESET];
      end
   end

   // Plain storage; only the master and format bits steer this slice
   always_ff @(posedge clk) begin
      if (srst) begin
         mode <= MODE_RESET;
      end else if (reg_hit(reg_write, reg_addr, ADDR_MODE)) begin
         mode <= reg_wdata;
      end
   end

   // Mask shares the status layout
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask <= IRQ_RESET;
      end else if (reg_hit(reg_write, reg_addr, ADDR_IRQ_MASK)) begin
         irq_mask <= reg_wdata[2:0];
      end
   end

   // Start/stop sequencer; each step holds the lines for COND_WAIT + 1 cycles
   always_ff @(posedge clk) begin
      if (srst || control_part_reset) begin
         state <= ST_IDLE;
         wait_cnt <= 16'h0000;
         fsm_sda_low <= 1'b0;
         fsm_scl_low <= 1'b0;
         ev_done <= 1'b0;
      end else begin
         ev_done <= 1'b0;
         if (!wait_over) begin
            wait_cnt <= wait_cnt - 16'h0001;
         end
         unique case (state)
            ST_IDLE: begin
               if (issue_start) begin
                  wait_cnt <= 16'(COND_WAIT);
                  fsm_sda_low <= 1'b0;
                  // A held bus needs SDA up before SCL up: repeated start
                  state <= fsm_scl_low ? ST_RS_SDA_UP : ST_RS_SCL_UP;
               // From a free bus this shows a start first, then the stop
               end else if (issue_stop) begin
                  wait_cnt <= 16'(COND_WAIT);
                  fsm_sda_low <= 1'b1;
                  state <= ST_STOP_SDA_LOW;
               end
            end
            ST_RS_SDA_UP: begin
               if (wait_over) begin
                  fsm_scl_low <= 1'b0;
                  wait_cnt <= 16'(COND_WAIT);
                  state <= ST_RS_SCL_UP;
               end
            end
            ST_RS_SCL_UP: begin
               if (wait_over) begin
                  fsm_sda_low <= 1'b1;
                  wait_cnt <= 16'(COND_WAIT);
                  state <= ST_START_SDA_LOW;
               end
            end
            ST_START_SDA_LOW: begin
               if (wait_over) begin
                  fsm_scl_low <= 1'b1;
                  wait_cnt <= 16'(COND_WAIT);
                  state <= ST_START_SCL_LOW;
               end
            end
            // SCL is left held low until the next command
            ST_START_SCL_LOW: begin
               if (wait_over) begin
                  ev_done <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_STOP_SDA_LOW: begin
               if (wait_over) begin
                  fsm_scl_low <= 1'b0;
                  wait_cnt <= 16'(COND_WAIT);
                  state <= ST_STOP_SCL_UP;
               end
            end
            ST_STOP_SCL_UP: begin
               if (wait_over) begin
                  fsm_sda_low <= 1'b0;
                  wait_cnt <= 16'(COND_WAIT);
                  state <= ST_STOP_SDA_UP;
               end
            end
            ST_STOP_SDA_UP: begin
               if (wait_over) begin
                  ev_done <= 1'b1;
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Pin drivers registered so the readback matches the pin exactly
   always_ff @(posedge clk) begin
      if (srst) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= sw_sda_low || fsm_sda_low;
      end
   end

   // SCL is only ever pulled by the sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         scl_oe <= 1'b0;
      end else begin
         scl_oe <= fsm_scl_low;
      end
   end

   // Sticky events; a new event beats the clear-on-read
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_status <= IRQ_RESET;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (status_read) begin
               irq_status[i] <= 1'b0;
            end
         end
         if (ev_start && watch_bus) begin
            irq_status[BIT_EV_START_SEEN] <= 1'b1;
         end
         if (ev_stop && watch_bus) begin
            irq_status[BIT_EV_STOP_SEEN] <= 1'b1;
         end
         if (ev_done) begin
            irq_status[BIT_EV_COND_DONE] <= 1'b1;
         end
      end
   end

   // Registered level, one cycle behind status and mask
   always_ff @(posedge clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            ADDR_BUS_COND: reg_rdata <= bus_cond_view(bus_occupied, sda_oe, scl_oe,
               control_part_reset);
            ADDR_MODE: reg_rdata <= mode;
            ADDR_IRQ_STATUS: reg_rdata <= {5'h00, irq_status};
            ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // bus_condition_ctrl

// ---- bench/bus_node_model.sv ----
`timescale 1ns/10ps
// Other node on the wire pair; both lines are open drain with pull-ups
module bus_node_model (
   input wire logic clk,
   input wire logic sda_oe,
   input wire logic scl_oe,
   output logic sda_in,
   output logic scl_in
);
   logic node_sda = 1'b0;
   logic node_scl = 1'b0;
   // Released lines float to the pull-up level
   assign sda_in = !(sda_oe || node_sda);
   assign scl_in = !(scl_oe || node_scl);
   // SCL stands still between frames; 8 clk is about half a link period
   task frame_start;
      @(posedge clk);
      node_sda <= 1'b1;
      repeat (8) @(posedge clk);
      node_scl <= 1'b1;
   endtask
   task frame_stop;
      @(posedge clk);
      node_scl <= 1'b0;
      repeat (8) @(posedge clk);
      node_sda <= 1'b0;
   endtask
endmodule // bus_node_model

// ---- bench/bus_condition_ctrl_sva.sv ----
`timescale 1ns/10ps
module bus_condition_ctrl_sva
   import bus_cond_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic scl_oe,
   input wire logic scl_out,
   input wire logic sda_oe,
   input wire logic sda_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic master;
   logic bc_wr;
   logic bc_rd;
   assign bc_wr = reg_write && reg_addr == ADDR_BUS_COND;
   always_ff @(posedge clk) begin
      if (srst) begin
         master <= 1'b0;
         bc_rd <= 1'b0;
      end else begin
         bc_rd <= reg_read && reg_addr == ADDR_BUS_COND;
         if (reg_write && reg_addr == ADDR_MODE) begin
            master <= reg_wdata[BIT_MASTER_SELECT];
         end
      end
   end
   a_pins_open_drain: assert property (sda_out == 1'b0 && scl_out == 1'b0)
      else $error("pin output value not low");
   a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_fixed_ones_read: assert property (bc_rd |-> reg_rdata[6] && reg_rdata[4] && reg_rdata[0])
      else $error("fixed bit read as 0");
   a_sda_readback: assert property (bc_rd |-> reg_rdata[5] == !$past(sda_oe))
      else $error("sda value readback wrong");
   a_scl_monitor: assert property (bc_rd |-> reg_rdata[3] == !$past(scl_oe))
      else $error("scl monitor wrong");
   a_sda_drive_low: assert property (bc_wr && reg_wdata[6:4] == 3'b100 |-> ##[1:2] sda_oe)
      else $error("sda not driven low");
   a_slave_refused: assert property (bc_wr && reg_wdata[7:6] == 2'b10 && reg_wdata[4] && !master
      && !sda_oe |=> !sda_oe [*8])
      else $error("condition issued outside master mode");
   a_inhibit_no_cmd: assert property (bc_wr && reg_wdata[6] && reg_wdata[4] && !sda_oe && !scl_oe
      |=> !sda_oe [*8])
      else $error("condition issued with inhibit set");
   a_part_reset_scl: assert property (bc_wr && reg_wdata[1] |-> ##3 !scl_oe)
      else $error("scl still held after control part reset");
endmodule // bus_condition_ctrl_sva
bind bus_condition_ctrl bus_condition_ctrl_sva bus_condition_ctrl_sva_inst (.clk(clk), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .scl_oe(scl_oe), .scl_out(scl_out), .sda_oe(sda_oe), .sda_out(sda_out));

// ---- bench/test_bus_condition_ctrl.sv ----
`timescale 1ns/10ps
module test_bus_condition_ctrl;
   import bus_cond_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, irq;
   logic [7:0] modes [2] = '{8'h20, 8'h30};
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   bus_condition_ctrl #(.COND_WAIT(4)) bus_condition_ctrl_inst (.clk(clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
   bus_node_model bus_node_model_inst (.clk(clk), .sda_oe(sda_oe), .scl_oe(scl_oe),
      .sda_in(sda_in), .scl_in(scl_in));
   initial forever #4 clk = ~clk;
   task close_out;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] k);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      cmp("reg_rdata", e & k, reg_rdata & k);
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wait_irq;
      int i;
      i = 0;
      while (irq !== 1'b1 && i < 300) begin
         @(posedge clk);
         #1;
         i++;
      end
      cmp("irq", 8'h01, {7'h00, irq});
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd(ADDR_BUS_COND, 8'h7D, 8'hFF);
      rd(4'h9, 8'h00, 8'hFF);
      wr(ADDR_IRQ_MASK, 8'h03);
      bus_node_model_inst.frame_start();
      idle(8);
      cmp("irq", 8'h01, {7'h00, irq});
      rd(ADDR_BUS_COND, 8'h80, 8'h80);
      rd(ADDR_IRQ_STATUS, 8'h01, 8'h07);
      bus_node_model_inst.frame_stop();
      idle(8);
      rd(ADDR_BUS_COND, 8'h00, 8'h80);
      rd(ADDR_IRQ_STATUS, 8'h02, 8'h07);
      idle(3);
      cmp("irq", 8'h00, {7'h00, irq});
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_MODE, 8'h01);
      bus_node_model_inst.frame_start();
      idle(8);
      rd(ADDR_BUS_COND, 8'h00, 8'h80);
      bus_node_model_inst.frame_stop();
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_BUS_COND, 8'h50);
      idle(4);
      rd(ADDR_BUS_COND, 8'h20, 8'h20);
      wr(ADDR_BUS_COND, 8'h40);
      idle(8);
      cmp("sda_oe", 8'h01, {7'h00, sda_oe});
      rd(ADDR_BUS_COND, 8'h80, 8'hA0);
      wr(ADDR_BUS_COND, 8'h60);
      idle(8);
      cmp("sda_oe", 8'h00, {7'h00, sda_oe});
      rd(ADDR_BUS_COND, 8'h20, 8'hA0);
      // Guard kept at 1 so no SDA value write lands mid-transfer
      wr(ADDR_IRQ_MASK, 8'h04);
      for (int j = 0; j < 2; j++) begin
         wr(ADDR_MODE, modes[j]);
         for (int r = 0; r < 2; r++) begin
            wr(ADDR_BUS_COND, 8'h90);
            wait_irq();
            rd(ADDR_IRQ_STATUS, 8'h04, 8'h04);
            cmp("oe", 8'h03, {6'h00, sda_oe, scl_oe});
            rd(ADDR_BUS_COND, 8'h80, 8'h88);
         end
         wr(ADDR_BUS_COND, 8'h10);
         wait_irq();
         rd(ADDR_IRQ_STATUS, 8'h04, 8'h04);
         idle(2);
         cmp("irq", 8'h00, {7'h00, irq});
         cmp("oe", 8'h00, {6'h00, sda_oe, scl_oe});
         rd(ADDR_BUS_COND, 8'h08, 8'h88);
      end
      wr(ADDR_BUS_COND, 8'h90);
      idle(30);
      wr(ADDR_BUS_COND, 8'h52);
      idle(4);
      cmp("oe", 8'h00, {6'h00, sda_oe, scl_oe});
      rd(ADDR_BUS_COND, 8'h02, 8'h02);
      rd(ADDR_MODE, 8'h30, 8'h30);
      wr(ADDR_BUS_COND, 8'h50);
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_BUS_COND, 8'h90);
      idle(40);
      cmp("oe", 8'h00, {6'h00, sda_oe, scl_oe});
      close_out();
   end
endmodule // test_bus_condition_ctrl
